// ===== common/osg_pkg.sv
// package for the output switch and overvoltage guard block
// assumes one 10 MHz system clock and an AXI4-Lite register master
// Notes on behaviour
// - output on: enable with zero setpoints about 2 ms, then apply setpoints
// - off with sink: zero setpoints, sink on 300 ms, then high impedance
// - off without sink: zero setpoints, go high impedance at once, no sink
// - off: output and mode indicators dark; on: output and active mode indicators lit
// - trigger holding output off wins; on command ignored, event B bit 4 set
// - rejected manual on request shows error code 073 briefly
// - overvoltage guard overrides regulators using its own comparator input
// - shutdown mode: off after voltage at or above threshold for hold time
// - recall mode: request stored setup slot 1..15 instead of shutdown
// - hold time zero: comparator switches output off directly
// - voltage drop below threshold abandons pending trip, timing restarts
// - hold time 0..65535 seconds, zero after reset
// - guard enabled indicator, plus trip indicator after guard shutdown
// - threshold stored, max 80.00 V in 0.02 V steps, default maximum
// - power result is measured voltage times measured current
// - either measurement out of range gives +/-999999 overload result
package osg_pkg;
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned TICK_US = 1000;
	localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
	localparam int unsigned RAMP_MS = 2;
	localparam int unsigned SINK_MS = 300;
	localparam int unsigned MS_PER_S = 1000;
	localparam logic [11:0] OV_MAX_STEPS = 12'h0_FA0; // 80.00 V / 0.02 V
	localparam logic [23:0] PWR_OVL = 24'h0F_423F;     // 999999
	localparam logic [7:0] ERR_CODE = 8'h49;           // 073
	localparam int unsigned ERR_SHOW_MS = 1000;
	localparam int unsigned EVB_OUTPUT_ENABLE_ERROR_FLAG_BIT = 4;
	// byte addresses
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_OVP = 8'h04;
	localparam logic [7:0] A_HOLD = 8'h08;
	localparam logic [7:0] A_STAT = 8'h0C;
	localparam logic [7:0] A_EVB = 8'h10;
	localparam logic [7:0] A_MASK = 8'h14;
	localparam logic [7:0] A_PWR = 8'h18;
	localparam logic [7:0] A_SETP = 8'h1C;
	// status / event bits
	localparam int unsigned EV_TRIP = 0;
	localparam int unsigned EV_RECALL = 1;
	localparam int unsigned EV_REJ = 2;
	localparam int unsigned EV_W = 5;
	typedef enum logic [1:0] {OVP_OFF, OVP_ON, OVP_RCL} osg_ovp_mode_t;
	typedef enum logic [1:0] {MODE_CV, MODE_CC, MODE_CP} osg_ctl_mode_t;
	typedef struct packed {
		logic out_led;
		logic cv_led;
		logic cc_led;
		logic cp_led;
		logic ovp_on_led;
		logic ovp_trip_led;
	} osg_leds_t;
	typedef struct packed {
		logic [15:0] u;
		logic [15:0] i;
		logic u_ovr;
		logic i_ovr;
		logic u_neg;
	} osg_meas_t;
endpackage

// ===== core/osg_power.sv
// output power from measured voltage and current
// assumes measurements are synchronous to clk_sys
`timescale 1ns/10ps
module osg_power (
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// measurement in
	input osg_pkg::osg_meas_t meas,
	// result
	output logic [31:0] power,
	output logic overload
);
	wire logic [31:0] prod = meas.u * meas.i;
	wire logic ovl = meas.u_ovr | meas.i_ovr;
	wire logic [31:0] ovl_val = meas.u_neg ? -{8'h00, osg_pkg::PWR_OVL} : {8'h00, osg_pkg::PWR_OVL};
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			power <= 32'h0000_0000;
			overload <= 1'b0;
		end else begin
			power <= ovl ? ovl_val : prod;
			overload <= ovl;
		end
	end
endmodule

// ===== core/osg_top.sv
// output switching sequencer with overvoltage guard and AXI4-Lite registers
// assumes the comparator, trigger and control mode straps come from pins; host is AXI4-Lite
//
// Chosen here: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
module osg_top #(
	parameter int unsigned TICK_CYC = osg_pkg::TICK_CYC
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// analog side pins
	input wire logic ov_cmp_pin,
	input wire logic trig_off_pin,
	input wire logic [1:0] ctl_mode_pin,
	input osg_pkg::osg_meas_t meas,
	// power stage
	output logic out_enable,
	output logic sink_on,
	output logic [15:0] uset_out,
	output logic [15:0] iset_out,
	output logic [11:0] ov_dac,
	// recall request and display
	output logic recall_req,
	output logic [3:0] recall_slot,
	output logic [7:0] err_code,
	output osg_pkg::osg_leds_t leds,
	output logic irq
);
	typedef enum logic [1:0] {ST_OFF, ST_RAMP, ST_ON, ST_SINK} osg_state_t;

	// pin synchronisers
	logic [1:0] cmp_sync_reg;
	logic [1:0] trig_sync_reg;
	logic [1:0] m0_sync_reg;
	logic [1:0] m1_sync_reg;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			cmp_sync_reg <= 2'h0;
			trig_sync_reg <= 2'h0;
			m0_sync_reg <= 2'h0;
			m1_sync_reg <= 2'h0;
		end else begin
			cmp_sync_reg <= {cmp_sync_reg[0], ov_cmp_pin};
			trig_sync_reg <= {trig_sync_reg[0], trig_off_pin};
			m0_sync_reg <= {m0_sync_reg[0], ctl_mode_pin[0]};
			m1_sync_reg <= {m1_sync_reg[0], ctl_mode_pin[1]};
		end
	end
	wire logic ov_high = cmp_sync_reg[1];
	wire logic trig_hold = trig_sync_reg[1];
	wire logic [1:0] mode_now = {m1_sync_reg[1], m0_sync_reg[1]};

	// millisecond tick
	logic [15:0] tick_cnt_reg;
	wire logic tick = (tick_cnt_reg == 16'(TICK_CYC - 1));
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) tick_cnt_reg <= 16'h0000;
		else tick_cnt_reg <= tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
	end

	// registers
	logic [31:0] ctrl_reg;    // 0 trig_mode, 1 sink_en, 2 manual, 3 on cmd, 4 off cmd
	logic [31:0] ovp_reg;     // [1:0] mode, [7:4] recall slot
	logic [15:0] hold_reg;
	logic [11:0] thr_reg;
	logic [31:0] setp_reg;    // [15:0] uset, [31:16] iset
	logic [osg_pkg::EV_W-1:0] evb_reg;
	logic [osg_pkg::EV_W-1:0] mask_reg;
	wire logic [31:0] pwr;
	wire logic pwr_ovl;

	osg_power u_power (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.meas(meas),
		.power(pwr),
		.overload(pwr_ovl)
	);

	// axi write channel: take address and data in either order
	logic aw_held_reg;
	logic w_held_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
	wire logic aw_fire = s_axi_awvalid && s_axi_awready;
	wire logic w_fire = s_axi_wvalid && s_axi_wready;
	wire logic aw_have = aw_held_reg || aw_fire;
	wire logic w_have = w_held_reg || w_fire;
	wire logic wr_go = aw_have && w_have;
	wire logic [7:0] wa = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
	wire logic [31:0] wd = w_held_reg ? w_data_reg : s_axi_wdata;
	wire logic [3:0] ws = w_held_reg ? w_strb_reg : s_axi_wstrb;
	wire logic wr_ok = wa inside {osg_pkg::A_CTRL, osg_pkg::A_OVP, osg_pkg::A_HOLD,
		osg_pkg::A_STAT, osg_pkg::A_EVB, osg_pkg::A_MASK, osg_pkg::A_PWR, osg_pkg::A_SETP};
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else begin
			if (aw_fire) aw_addr_reg <= s_axi_awaddr;
			if (w_fire) begin
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			aw_held_reg <= aw_have && !wr_go;
			w_held_reg <= w_have && !wr_go;
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
			end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
		end
	end

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) if (st[b]) r[8*b +: 8] = nw[8*b +: 8];
		return r;
	endfunction

	wire logic wr_ctrl = wr_go && wa == osg_pkg::A_CTRL;
	wire logic [31:0] ctrl_m = merge(ctrl_reg, wd, ws);
	wire logic on_cmd = wr_ctrl && ctrl_m[3];
	wire logic off_cmd = wr_ctrl && ctrl_m[4];
	wire logic trig_mode = ctrl_reg[0];
	wire logic sink_en = ctrl_reg[1];
	wire logic manual = ctrl_m[2];
	wire logic [31:0] ovp_m = merge(ovp_reg, wd, ws);
	wire logic [31:0] hold_m = merge({16'h0000, hold_reg}, wd, ws);
	wire logic [31:0] thr_m = merge({20'h0_0000, thr_reg}, wd, ws);
	wire logic [31:0] evb_clr = merge(32'h0000_0000, wd, ws);
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ctrl_reg <= 32'h0000_0000;
			ovp_reg <= {28'h000_0001, 4'h1}; // guard on, slot 1
			hold_reg <= 16'h0000;
			thr_reg <= osg_pkg::OV_MAX_STEPS;
			setp_reg <= 32'h0000_0000;
			mask_reg <= '0;
		end else if (wr_go) begin
			unique case (wa)
				osg_pkg::A_CTRL: ctrl_reg <= {27'h000_0000, 2'h0, ctrl_m[2:0]};
				osg_pkg::A_OVP: ovp_reg <= {24'h00_0000, ovp_m[7:4], 2'h0, ovp_m[1:0]};
				osg_pkg::A_HOLD: hold_reg <= hold_m[15:0];
				osg_pkg::A_STAT: thr_reg <= (thr_m[11:0] > osg_pkg::OV_MAX_STEPS) ?
					osg_pkg::OV_MAX_STEPS : thr_m[11:0];
				osg_pkg::A_MASK: mask_reg <= wd[osg_pkg::EV_W-1:0];
				osg_pkg::A_SETP: setp_reg <= merge(setp_reg, wd, ws);
				default: ;
			endcase
		end
	end
	assign ov_dac = thr_reg;

	// output state machine
	osg_state_t st_reg;
	osg_state_t st_next;
	logic [15:0] ms_reg;
	logic [15:0] ms_next;
	logic tripped_reg;
	logic [9:0] sub_ms_reg;
	logic [15:0] sec_reg;
	wire osg_pkg::osg_ovp_mode_t ovp_mode = osg_pkg::osg_ovp_mode_t'(ovp_reg[1:0]);
	wire logic out_live = st_reg != ST_OFF && st_reg != ST_SINK;
	wire logic reject = on_cmd && trig_mode && trig_hold;
	wire logic hold_done = sec_reg == hold_reg && sub_ms_reg == 10'h000;
	wire logic ov_fire = ov_high && out_live && ovp_mode != osg_pkg::OVP_OFF &&
		(hold_reg == 16'h0000 || hold_done);
	wire logic trip = ov_fire && ovp_mode == osg_pkg::OVP_ON;
	wire logic rcl = ov_fire && ovp_mode == osg_pkg::OVP_RCL;
	wire logic trig_off = trig_mode && trig_hold && out_live;
	wire logic go_off = off_cmd || trip || trig_off;

	// hold timer: seconds resolved to milliseconds, reset whenever voltage drops
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sub_ms_reg <= 10'h000;
			sec_reg <= 16'h0000;
		end else if (!ov_high || !out_live || ov_fire) begin
			sub_ms_reg <= 10'h000;
			sec_reg <= 16'h0000;
		end else if (tick && !hold_done) begin
			if (sub_ms_reg == 10'(osg_pkg::MS_PER_S - 1)) begin
				sub_ms_reg <= 10'h000;
				sec_reg <= sec_reg + 16'h0001;
			end else sub_ms_reg <= sub_ms_reg + 10'h001;
		end
	end

	always_comb begin
		st_next = st_reg;
		ms_next = (tick && ms_reg != 16'h0000) ? ms_reg - 16'h0001 : ms_reg;
		unique case (st_reg)
			ST_OFF: if (on_cmd && !reject) begin
				st_next = ST_RAMP;
				ms_next = 16'(osg_pkg::RAMP_MS);
			end
			ST_RAMP, ST_ON: if (go_off) begin
				st_next = (sink_en && !trip) ? ST_SINK : ST_OFF;
				ms_next = 16'(osg_pkg::SINK_MS);
			end else if (st_reg == ST_RAMP && ms_reg == 16'h0000) st_next = ST_ON;
			ST_SINK: if (ms_reg == 16'h0000) st_next = ST_OFF;
		endcase
	end
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			st_reg <= ST_OFF;
			ms_reg <= 16'h0000;
			tripped_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			ms_reg <= ms_next;
			if (trip) tripped_reg <= 1'b1;
			else if (st_reg == ST_OFF && on_cmd && !reject) tripped_reg <= 1'b0;
		end
	end

	// power stage outputs; guard trip skips the sink and cuts at once
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			out_enable <= 1'b0;
			sink_on <= 1'b0;
			uset_out <= 16'h0000;
			iset_out <= 16'h0000;
			recall_req <= 1'b0;
			recall_slot <= 4'h0;
		end else begin
			out_enable <= st_next == ST_RAMP || st_next == ST_ON;
			sink_on <= st_next == ST_SINK;
			uset_out <= st_next == ST_ON ? setp_reg[15:0] : 16'h0000;
			iset_out <= st_next == ST_ON ? setp_reg[31:16] : 16'h0000;
			recall_req <= rcl;
			if (rcl) recall_slot <= ovp_reg[7:4];
		end
	end

	// error display of rejected manual on request
	logic [10:0] err_ms_reg;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) err_ms_reg <= 11'h000;
		else if (reject && manual) err_ms_reg <= 11'(osg_pkg::ERR_SHOW_MS);
		else if (tick && err_ms_reg != 11'h000) err_ms_reg <= err_ms_reg - 11'h001;
	end
	assign err_code = err_ms_reg != 11'h000 ? osg_pkg::ERR_CODE : 8'h00;

	// indicators
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) leds <= '0;
		else begin
			leds.out_led <= out_live;
			leds.cv_led <= out_live && mode_now == 2'(osg_pkg::MODE_CV);
			leds.cc_led <= out_live && mode_now == 2'(osg_pkg::MODE_CC);
			leds.cp_led <= out_live && mode_now == 2'(osg_pkg::MODE_CP);
			leds.ovp_on_led <= ovp_mode != osg_pkg::OVP_OFF;
			leds.ovp_trip_led <= tripped_reg;
		end
	end

	// sticky events: set wins over write-one-to-clear
	wire logic [osg_pkg::EV_W-1:0] ev_set = (osg_pkg::EV_W)'(
		(32'(trip) << osg_pkg::EV_TRIP) | (32'(rcl) << osg_pkg::EV_RECALL) |
		(32'(reject && manual) << osg_pkg::EV_REJ) | (32'(reject) << osg_pkg::EVB_OUTPUT_ENABLE_ERROR_FLAG_BIT));
	wire logic wr_evb = wr_go && wa == osg_pkg::A_EVB;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) evb_reg <= '0;
		else evb_reg <= (evb_reg & ~(wr_evb ? evb_clr[osg_pkg::EV_W-1:0] : '0)) | ev_set;
	end
	assign irq = |(evb_reg & mask_reg);

	// axi read channel
	logic [31:0] rd_mux;
	always_comb begin
		unique case (s_axi_araddr)
			osg_pkg::A_CTRL: rd_mux = ctrl_reg;
			osg_pkg::A_OVP: rd_mux = ovp_reg;
			osg_pkg::A_HOLD: rd_mux = {16'h0000, hold_reg};
			osg_pkg::A_STAT: rd_mux = {13'h0000, tripped_reg, st_reg, 4'h0, thr_reg};
			osg_pkg::A_EVB: rd_mux = {27'h000_0000, evb_reg};
			osg_pkg::A_MASK: rd_mux = {27'h000_0000, mask_reg};
			osg_pkg::A_PWR: rd_mux = pwr;
			osg_pkg::A_SETP: rd_mux = setp_reg;
			default: rd_mux = 32'h0000_0000;
		endcase
	end
	wire logic rd_ok = s_axi_araddr inside {osg_pkg::A_CTRL, osg_pkg::A_OVP, osg_pkg::A_HOLD,
		osg_pkg::A_STAT, osg_pkg::A_EVB, osg_pkg::A_MASK, osg_pkg::A_PWR, osg_pkg::A_SETP};
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_mux;
			s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
		end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
	end
endmodule

// ===== dv/osg_host.sv
// host model issuing register commands over axi4-lite
// assumes the slave answers in its own time; the bench watchdog ends hangs
`timescale 1ns/10ps
module osg_host (
	// clock
	input wire logic clk_sys,
	// write side
	output logic [7:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	// read side
	output logic [7:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	output logic s_axi_rready
);
	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
	end
	// released payload shows the inverse so stale values never look valid
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~a;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~d;
			end
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arvalid <= 1'b0;
				s_axi_araddr <= ~a;
			end
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
endmodule

// ===== dv/osg_top_bench.sv
// self-checking bench for the output switch and overvoltage guard
// assumes a 1 ms tick scaled down to ten cycles per millisecond
`timescale 1ns/10ps
module osg_top_bench;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] s_axi_awaddr, s_axi_araddr, err_code;
	logic [31:0] s_axi_wdata, s_axi_rdata, rv;
	logic [3:0] s_axi_wstrb, recall_slot;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic ov_cmp_pin = 1'b0;
	logic trig_off_pin = 1'b0;
	logic [1:0] ctl_mode_pin = 2'h0;
	osg_pkg::osg_meas_t meas = '0;
	logic out_enable, sink_on, recall_req, irq;
	logic [15:0] uset_out, iset_out;
	logic [11:0] ov_dac;
	osg_pkg::osg_leds_t leds;
	int failures = 0;
	int checks_done = 0;
	always #50 clk_sys = ~clk_sys;
	osg_top #(.TICK_CYC(10)) dut (.*);
	osg_host host (.*);
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			failures++;
			$display("wrong value at %0t: saw %h wanted %h", $time, s, e);
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge clk_sys);
		failures++;
		test_done;
	end
	initial begin
		int n;
		cyc(5);
		resetn <= 1'b1;
		cyc(1);
		host.rd(osg_pkg::A_HOLD, rv, rr);
		chk(rv, 32'h0000_0000);
		chk(ov_dac, 32'h0000_0FA0);
		chk(leds.ovp_on_led, 1);
		host.wr(osg_pkg::A_SETP, 32'h0200_0123);
		host.wr(osg_pkg::A_CTRL, 32'h0000_000A);
		cyc(3);
		chk(out_enable, 1);
		chk({uset_out, iset_out}, 32'h0000_0000);
		cyc(30);
		chk({uset_out, iset_out}, 32'h0123_0200);
		for (int m = 0; m < 3; m++) begin
			ctl_mode_pin <= 2'(m);
			cyc(5);
			chk({leds.out_led, leds.cv_led, leds.cc_led, leds.cp_led}, 4'h8 | (4'h4 >> m));
		end
		host.wr(osg_pkg::A_CTRL, 32'h0000_0012);
		cyc(2800);
		chk(sink_on, 1);
		chk({uset_out, iset_out}, 32'h0000_0000);
		cyc(400);
		chk({sink_on, out_enable, leds.out_led, leds.cp_led}, 0);
		$display("on and sink off done");
		host.wr(osg_pkg::A_CTRL, 32'h0000_0008);
		cyc(30);
		host.wr(osg_pkg::A_CTRL, 32'h0000_0010);
		cyc(3);
		chk({sink_on, out_enable, uset_out}, 0);
		$display("plain off done");
		// trigger mode is armed first; the pin needs its synchroniser delay too
		trig_off_pin <= 1'b1;
		host.wr(osg_pkg::A_CTRL, 32'h0000_0005);
		host.wr(osg_pkg::A_CTRL, 32'h0000_000D);
		cyc(3);
		chk(out_enable, 0);
		chk(err_code, osg_pkg::ERR_CODE);
		host.rd(osg_pkg::A_EVB, rv, rr);
		chk(rv, 32'h0000_0014);
		host.wr(osg_pkg::A_MASK, 32'h0000_0010);
		chk(irq, 1);
		host.wr(osg_pkg::A_MASK, 32'h0000_0000);
		chk(irq, 0);
		host.wr(osg_pkg::A_MASK, 32'h0000_0010);
		host.wr(osg_pkg::A_EVB, 32'h0000_0014);
		cyc(2);
		chk(irq, 0);
		trig_off_pin <= 1'b0;
		host.wr(osg_pkg::A_CTRL, 32'h0000_0000);
		$display("trigger priority done");
		host.wr(osg_pkg::A_CTRL, 32'h0000_0008);
		cyc(30);
		ov_cmp_pin <= 1'b1;
		cyc(6);
		chk({out_enable, leds.ovp_trip_led}, 2'b01);
		ov_cmp_pin <= 1'b0;
		cyc(50);
		chk(out_enable, 0);
		host.wr(osg_pkg::A_CTRL, 32'h0000_0008);
		cyc(3);
		chk(out_enable, 1);
		host.wr(osg_pkg::A_OVP, 32'h0000_0052);
		ov_cmp_pin <= 1'b1;
		n = 0;
		while (recall_req !== 1'b1 && n < 20) begin
			cyc(1);
			n++;
		end
		chk({recall_req, recall_slot, out_enable}, 6'h2B);
		ov_cmp_pin <= 1'b0;
		host.rd(osg_pkg::A_EVB, rv, rr);
		chk(rv[1:0], 2'b11);
		// clear old events so the hold test sees only its own trip
		host.wr(osg_pkg::A_EVB, 32'h0000_001F);
		$display("guard direct and recall done");
		host.wr(osg_pkg::A_OVP, 32'h0000_0001);
		host.wr(osg_pkg::A_HOLD, 32'h0000_0001);
		ov_cmp_pin <= 1'b1;
		cyc(6000);
		ov_cmp_pin <= 1'b0;
		cyc(5);
		ov_cmp_pin <= 1'b1;
		cyc(9000);
		chk(out_enable, 1);
		cyc(1500);
		chk(out_enable, 0);
		host.rd(osg_pkg::A_EVB, rv, rr);
		chk(rv[osg_pkg::EV_TRIP], 1);
		ov_cmp_pin <= 1'b0;
		$display("guard hold done");
		meas <= '{u: 16'h0064, i: 16'h00C8, default: '0};
		cyc(3);
		host.rd(osg_pkg::A_PWR, rv, rr);
		chk(rv, 32'h0000_4E20);
		meas <= '{u: 16'h0064, i: 16'h00C8, u_ovr: 1'b1, default: '0};
		cyc(3);
		host.rd(osg_pkg::A_PWR, rv, rr);
		chk(rv, 32'h000F_423F);
		host.rd(8'h40, rv, rr);
		chk(rr, 2'h2);
		$display("power and map done");
		test_done;
	end
endmodule

// ===== dv/osg_top_properties.sv
// concurrent checks on the output switch and overvoltage guard ports
// assumes it is bound onto osg_top and shares its tick parameter
`timescale 1ns/10ps
module osg_top_properties #(
	parameter int unsigned TICK_CYC = 10
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// watched outputs
	input wire logic out_enable,
	input wire logic sink_on,
	input wire logic [15:0] uset_out,
	input wire logic [15:0] iset_out,
	input wire logic [11:0] ov_dac,
	input wire logic recall_req,
	input wire logic [7:0] err_code,
	input osg_pkg::osg_leds_t leds
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// length of the current discharge burst in cycles
	logic [31:0] sink_cnt_reg;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			sink_cnt_reg <= '0;
		else
			sink_cnt_reg <= sink_on ? sink_cnt_reg + 32'h0000_0001 : '0;
	end
	property p_ramp_zero;
		$rose(out_enable) |-> (uset_out == 16'h0000 && iset_out == 16'h0000)[*8];
	endproperty
	a_ramp_zero: assert property (p_ramp_zero) else $error("setpoints not zero at turn on");
	property p_sink_zero;
		sink_on |-> uset_out == 16'h0000 && iset_out == 16'h0000;
	endproperty
	a_sink_zero: assert property (p_sink_zero) else $error("setpoints live during sink");
	property p_sink_min;
		$fell(sink_on) |-> sink_cnt_reg >= 299 * TICK_CYC;
	endproperty
	a_sink_min: assert property (p_sink_min) else $error("sink burst too short");
	property p_sink_max;
		sink_cnt_reg <= 301 * TICK_CYC;
	endproperty
	a_sink_max: assert property (p_sink_max) else $error("sink burst too long");
	property p_sink_then_off;
		$fell(sink_on) |-> ##[0:2] !out_enable;
	endproperty
	a_sink_then_off: assert property (p_sink_then_off) else $error("output left on");
	property p_off_dark;
		!out_enable && !sink_on && !$past(out_enable) && !$past(out_enable, 2)
			|-> {leds.out_led, leds.cv_led, leds.cc_led, leds.cp_led} == 4'h0;
	endproperty
	a_off_dark: assert property (p_off_dark) else $error("indicator lit while off");
	property p_err_val;
		err_code == 8'h00 || err_code == osg_pkg::ERR_CODE;
	endproperty
	a_err_val: assert property (p_err_val) else $error("odd error code");
	property p_dac_max;
		ov_dac <= osg_pkg::OV_MAX_STEPS;
	endproperty
	a_dac_max: assert property (p_dac_max) else $error("threshold above maximum");
	property p_trip_off;
		$rose(leds.ovp_trip_led) |-> ##[0:2] !out_enable;
	endproperty
	a_trip_off: assert property (p_trip_off) else $error("trip lamp with output on");
	property p_recall_on;
		recall_req && $past(out_enable) |-> out_enable ##1 out_enable;
	endproperty
	a_recall_on: assert property (p_recall_on) else $error("recall shut output");
endmodule
bind osg_top osg_top_properties #(.TICK_CYC(TICK_CYC)) u_props (
	.clk_sys(clk_sys),
	.resetn(resetn),
	.out_enable(out_enable),
	.sink_on(sink_on),
	.uset_out(uset_out),
	.iset_out(iset_out),
	.ov_dac(ov_dac),
	.recall_req(recall_req),
	.err_code(err_code),
	.leds(leds)
);
